/* File: rtl/lsc_pkg.sv */
// Shared constants, types and helpers for the lighting store crossfade.
// Function
// - Preset mimic shows contributing files, cut/plus/zero/file only
// - Flag unfiled panel edits to preset store
// - Flag preset differing from mimic after zero-load
// - Flag preset channel dropped by output edit mid-fade
// - Flag preset altered by priming, direct or automatic
// - Each store scaled by its own master
// - Files hold unscaled levels
// - Fade target is preset-scaled, then output master applies
// - Merge toggle drives dimmers with per-channel maximum
// - Fade up and down toggle independently per press
// - Durations 1 to 70 s, infinite halts without stopping
// - Fade time fixed, rate scales with level difference
// - Per-fade progress on a 20-division scale
// - Priming switches on output-only channels at zero
// - Priming complete until an output-only channel appears
// - Auto crossfade primes and runs both fades
// - Auto status: inactive, active or modified
// - Most recent fade or auto press wins
// - Store set loads all levels, keeps on/off
// - Store off clears on states, keeps levels
// - File enable low blocks filing, not the clear-key erase
// - Clear key plus button erases files, power on
// - Zero-load switches on file channels at zero
// - Caution on load buttons while preset unfiled
package lsc_pkg;
  localparam int LEVEL_W    = 8;
  localparam int CH_IDX_W   = 8;
  localparam int FILE_IDX_W = 7;
  localparam int DUR_W      = 7;
  localparam int PROG_W     = 8;
  localparam int TRAVEL_W   = 5;
  localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 8'hFF;
  localparam logic [DUR_W-1:0] DUR_INFINITE = 7'h00;
  localparam logic [DUR_W-1:0] DUR_MAX      = 7'h46;
  localparam int TRAVEL_DIVS   = 20;
  localparam int PROG_STEPS    = 200;
  localparam logic [PROG_W-1:0] PROG_FULL = PROG_W'(PROG_STEPS);
  localparam int SEC_NS        = 1000000000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_CUT  = 3'b001,
    OP_PLUS = 3'b010,
    OP_ZERO = 3'b011,
    OP_FILE = 3'b100,
    OP_SET  = 3'b101,
    OP_OFF  = 3'b110
  } lsc_op_type;

  typedef enum logic [1:0] {
    XF_IDLE     = 2'b00,
    XF_ACTIVE   = 2'b01,
    XF_MODIFIED = 2'b10
  } lsc_xf_type;

  typedef struct packed {
    logic fadeUp;
    logic fadeDown;
    logic autoXf;
    logic prime;
    logic mix;
    logic chanWrite;
    logic fileGo;
    logic clearBtn;
  } lsc_btn_type;

  typedef struct packed {
    logic                preset;
    logic [CH_IDX_W-1:0] idx;
    logic                on;
    logic [LEVEL_W-1:0]  level;
  } lsc_chan_type;

  typedef struct packed {
    lsc_op_type            op;
    logic                  preset;
    logic [FILE_IDX_W-1:0] file;
  } lsc_file_type;

  typedef struct packed {
    lsc_btn_type        btn;
    lsc_chan_type       chan;
    lsc_file_type       fcmd;
    logic [LEVEL_W-1:0] setLevelOut;
    logic [LEVEL_W-1:0] setLevelPre;
    logic [LEVEL_W-1:0] masterOut;
    logic [LEVEL_W-1:0] masterPre;
    logic [DUR_W-1:0]   durUp;
    logic [DUR_W-1:0]   durDown;
    logic               fileKey;
    logic               clearKey;
    logic               sysPower;
    logic               consolePower;
  } lsc_panel_type;

  typedef struct packed {
    logic modFlag;
    logic zeroFlag;
    logic xferFlag;
    logic primeFlag;
    logic primeComplete;
    logic caution;
    logic mixOn;
  } lsc_status_type;

  // A factor of full scale passes the level through exactly.
  function automatic logic [LEVEL_W-1:0] scale_level(
    input logic [LEVEL_W-1:0] lvl,
    input logic [LEVEL_W-1:0] factor
  );
    logic [2*LEVEL_W:0] prod;
    prod = (2*LEVEL_W+1)'(lvl) * (2*LEVEL_W+1)'({1'b0, factor} + 9'h001);
    return prod[2*LEVEL_W-1:LEVEL_W];
  endfunction
endpackage

/* File: rtl/lsc_fade_timer.sv */
// Progress timer for one fade direction.
`timescale 1ns/100ps
module lsc_fade_timer
  import lsc_pkg::*;
#(
  parameter int SEC_CYCLES_P = SEC_CYCLES
)
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Control
  input  wire logic                toggleReq,
  input  wire logic                forceStart,
  input  wire logic                forceStop,
  input  wire logic [DUR_W-1:0]    duration,
  // Status
  output logic                     running,
  output logic                     halted,
  output logic [PROG_W-1:0]        progress,
  output logic [TRAVEL_W-1:0]      travel,
  output logic                     beginPulse,
  output logic                     donePulse
);
  localparam int STEP_CYCLES = SEC_CYCLES_P / PROG_STEPS;

  if (STEP_CYCLES < 2)
  begin : g_check
    $error("SEC_CYCLES_P too small for the progress resolution");
  end

  logic              running_r;
  logic [PROG_W-1:0] progress_r;
  logic [31:0]       stepCnt_r;
  logic [DUR_W-1:0]  secCnt_r;
  logic              halted_r;
  logic [TRAVEL_W-1:0] travel_r;
  logic              begin_r;
  logic              done_r;
  logic              startNow;
  logic              restart;
  logic              stepEnd;
  logic              advance;

  assign startNow = forceStart | (toggleReq & ~running_r);
  assign restart  = forceStart | (startNow & (progress_r == PROG_FULL));
  assign stepEnd  = running_r & (duration != DUR_INFINITE)
                  & (stepCnt_r == 32'(STEP_CYCLES - 1));
  // Each progress step lasts duration/200 s, so every channel finishes
  // together whatever its distance.
  assign advance  = stepEnd & (secCnt_r >= duration - 7'h01);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      running_r <= 1'b0;
    else if (forceStop)
      running_r <= 1'b0;
    else if (startNow)
      running_r <= 1'b1;
    else if (toggleReq)
      running_r <= 1'b0;
    else if (advance && progress_r == PROG_FULL - 8'h01)
      running_r <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || restart)
      progress_r <= '0;
    else if (advance)
      progress_r <= progress_r + 8'h01;
  end

  // An infinite setting freezes the counters but leaves running set.
  always_ff @(posedge clk_sys)
  begin
    if (rst || restart)
    begin
      stepCnt_r <= '0;
      secCnt_r  <= '0;
    end
    else if (running_r && duration != DUR_INFINITE)
    begin
      stepCnt_r <= stepEnd ? 32'h0 : stepCnt_r + 32'h1;
      if (stepEnd)
        secCnt_r <= advance ? 7'h00 : secCnt_r + 7'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      halted_r <= 1'b0;
      travel_r <= '0;
      begin_r  <= 1'b0;
      done_r   <= 1'b0;
    end
    else
    begin
      // Follows the next running state, so it never outlives running.
      halted_r <= ~forceStop & (startNow | (running_r & ~toggleReq))
                  & (duration == DUR_INFINITE);
      travel_r <= TRAVEL_W'(32'(progress_r) * TRAVEL_DIVS
                  / PROG_STEPS);
      begin_r  <= startNow & (forceStart | (progress_r == '0)
                  | (progress_r == PROG_FULL));
      done_r   <= advance & (progress_r == PROG_FULL - 8'h01);
    end
  end

  assign running    = running_r;
  assign halted     = halted_r;
  assign progress   = progress_r;
  assign travel     = travel_r;
  assign beginPulse = begin_r;
  assign donePulse  = done_r;
endmodule

/* File: rtl/lsc_dimmer_mix.sv */
// Master scaling and store merging for the dimmer outputs.
`timescale 1ns/100ps
module lsc_dimmer_mix
  import lsc_pkg::*;
#(
  parameter int NUM_CH = 16
)
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Stores
  input  wire logic [LEVEL_W-1:0]  outLvl [NUM_CH],
  input  wire logic [NUM_CH-1:0]   outOn,
  input  wire logic [LEVEL_W-1:0]  preLvl [NUM_CH],
  input  wire logic [NUM_CH-1:0]   preOn,
  // Control
  input  wire logic [LEVEL_W-1:0]  masterOut,
  input  wire logic [LEVEL_W-1:0]  masterPre,
  input  wire logic                mixOn,
  input  wire logic                enable,
  // Dimmers
  output logic [LEVEL_W-1:0]       dimmer [NUM_CH]
);
  function automatic logic [LEVEL_W-1:0] drive(
    input logic [LEVEL_W-1:0] lo,
    input logic [LEVEL_W-1:0] pr,
    input logic               merged
  );
    return (merged && pr > lo) ? pr : lo;
  endfunction

  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (rst || !enable)
        dimmer[i] <= LEVEL_ZERO;
      else
        dimmer[i] <= drive(
          outOn[i] ? scale_level(outLvl[i], masterOut) : LEVEL_ZERO,
          preOn[i] ? scale_level(preLvl[i], masterPre) : LEVEL_ZERO,
          mixOn);
    end
  end
endmodule

/* File: rtl/lsc_crossfade.sv */
// Store, file and crossfade control for the lighting console.
`timescale 1ns/100ps
module lsc_crossfade
  import lsc_pkg::*;
#(
  parameter int NUM_CH       = 16,
  parameter int NUM_FILE     = 100,
  parameter int SEC_CYCLES_P = SEC_CYCLES
)
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Operator panel, asynchronous
  input  wire lsc_panel_type         panel,
  // Dimmer drive
  output logic [LEVEL_W-1:0]         dimmer [NUM_CH],
  // Indicators
  output logic [NUM_FILE-1:0]        presetMimic,
  output lsc_status_type             status,
  output lsc_xf_type                 xfState,
  output logic                       upRunning,
  output logic                       downRunning,
  output logic                       upHalted,
  output logic                       downHalted,
  output logic [TRAVEL_W-1:0]        upTravel,
  output logic [TRAVEL_W-1:0]        downTravel
);
  if (NUM_CH > 2**CH_IDX_W || NUM_FILE > 2**FILE_IDX_W || NUM_CH < 1)
  begin : g_check
    $error("NUM_CH or NUM_FILE outside the index widths");
  end

  function automatic logic [LEVEL_W-1:0] interp(
    input logic [LEVEL_W-1:0] from,
    input logic [LEVEL_W-1:0] to,
    input logic [PROG_W-1:0]  prog
  );
    logic [LEVEL_W+PROG_W-1:0] span;
    span = (LEVEL_W+PROG_W)'(to > from ? to - from : from - to)
         * (LEVEL_W+PROG_W)'(prog) / (LEVEL_W+PROG_W)'(PROG_STEPS);
    return to > from ? from + span[LEVEL_W-1:0] : from - span[LEVEL_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Panel synchroniser; only the second stage is read.
  lsc_panel_type panelMeta_r;
  lsc_panel_type panelSync_r;
  lsc_btn_type   btnPrev_r;
  lsc_btn_type   press;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      panelMeta_r <= '0;
      panelSync_r <= '0;
      btnPrev_r   <= '0;
    end
    else
    begin
      panelMeta_r <= panel;
      panelSync_r <= panelMeta_r;
      btnPrev_r   <= panelSync_r.btn;
    end
  end
  assign press = panelSync_r.btn & ~btnPrev_r;
  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  logic [LEVEL_W-1:0]  outLvl_r  [NUM_CH];
  logic [LEVEL_W-1:0]  preLvl_r  [NUM_CH];
  logic [LEVEL_W-1:0]  upFrom_r  [NUM_CH];
  logic [LEVEL_W-1:0]  downFrom_r [NUM_CH];
  logic [LEVEL_W-1:0]  target    [NUM_CH];
  logic [LEVEL_W-1:0]  fileLvl_r [NUM_FILE][NUM_CH];
  logic [NUM_CH-1:0]   fileOn_r  [NUM_FILE];
  logic [NUM_CH-1:0]   outOn_r;
  logic [NUM_CH-1:0]   preOn_r;
  lsc_xf_type          xf_r;
  lsc_status_type      stat_r;
  logic [NUM_FILE-1:0] mimic_r;
  logic [NUM_FILE-1:0] fileHot;
  lsc_op_type          op;
  logic powerOk, fileOk, isPre, preCut, prePlus, preZero, preLoad;
  logic fileWrite, clearAll, primeReq, chanOut, chanPre, fadeActive;
  logic xfStart, xfStop, xfDone, upToggle, downToggle;
  logic upBegin, downBegin, downDone;
  logic [PROG_W-1:0] upProg, downProg;

  assign powerOk  = panelSync_r.sysPower & panelSync_r.consolePower;
  assign fileOk   = 32'(panelSync_r.fcmd.file) < NUM_FILE;
  assign op       = (press.fileGo && fileOk) ? panelSync_r.fcmd.op : OP_NONE;
  assign isPre    = panelSync_r.fcmd.preset;
  assign fileHot  = NUM_FILE'(1) << panelSync_r.fcmd.file;
  assign preCut   = op == OP_CUT;
  assign prePlus  = op == OP_PLUS;
  assign preZero  = op == OP_ZERO;
  assign fileWrite = op == OP_FILE && panelSync_r.fileKey && powerOk;
  assign preLoad  = preCut | (fileWrite & isPre);
  assign clearAll = press.clearBtn & panelSync_r.clearKey & powerOk;
  assign chanOut  = press.chanWrite & ~panelSync_r.chan.preset;
  assign chanPre  = press.chanWrite & panelSync_r.chan.preset;
  assign fadeActive = upRunning | downRunning;

  // A same-cycle auto press beats a fade press, as the later operation.
  assign xfStart    = press.autoXf & (xf_r == XF_IDLE);
  assign xfStop     = press.autoXf & (xf_r != XF_IDLE);
  assign upToggle   = press.fadeUp & ~press.autoXf;
  assign downToggle = press.fadeDown & ~press.autoXf;
  assign xfDone     = (xf_r != XF_IDLE) && !xfStart && !xfStop
                    && upProg == PROG_FULL && downProg == PROG_FULL;
  assign primeReq   = press.prime | xfStart;

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
      target[i] = preOn_r[i] ? scale_level(preLvl_r[i], panelSync_r.masterPre)
                             : LEVEL_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fade timers.
  lsc_fade_timer #(.SEC_CYCLES_P(SEC_CYCLES_P)) upTimer (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .toggleReq  (upToggle),
    .forceStart (xfStart),
    .forceStop  (xfStop),
    .duration   (panelSync_r.durUp),
    .running    (upRunning),
    .halted     (upHalted),
    .progress   (upProg),
    .travel     (upTravel),
    .beginPulse (upBegin),
    .donePulse  ()
  );

  lsc_fade_timer #(.SEC_CYCLES_P(SEC_CYCLES_P)) downTimer (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .toggleReq  (downToggle),
    .forceStart (xfStart),
    .forceStop  (xfStop),
    .duration   (panelSync_r.durDown),
    .running    (downRunning),
    .halted     (downHalted),
    .progress   (downProg),
    .travel     (downTravel),
    .beginPulse (downBegin),
    .donePulse  (downDone)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      xf_r <= XF_IDLE;
    else if (xfStart)
      xf_r <= XF_ACTIVE;
    else if (xfStop || xfDone)
      xf_r <= XF_IDLE;
    else if (xf_r == XF_ACTIVE && (upToggle || downToggle || upHalted
             || downHalted))
      xf_r <= XF_MODIFIED;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output store; fades interpolate from levels captured at fade start.
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (rst)
      begin
        upFrom_r[i]   <= LEVEL_ZERO;
        downFrom_r[i] <= LEVEL_ZERO;
      end
      else if (chanOut && panelSync_r.chan.idx == CH_IDX_W'(i))
      begin
        upFrom_r[i]   <= panelSync_r.chan.level;
        downFrom_r[i] <= panelSync_r.chan.level;
      end
      else
      begin
        if (upBegin)
          upFrom_r[i] <= outLvl_r[i];
        if (downBegin)
          downFrom_r[i] <= outLvl_r[i];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (rst)
      begin
        outLvl_r[i] <= LEVEL_ZERO;
        outOn_r[i]  <= 1'b0;
      end
      else if (chanOut && panelSync_r.chan.idx == CH_IDX_W'(i))
      begin
        outLvl_r[i] <= panelSync_r.chan.level;
        outOn_r[i]  <= panelSync_r.chan.on;
      end
      else if (op == OP_SET && !isPre)
        outLvl_r[i] <= panelSync_r.setLevelOut;
      else if (op == OP_OFF && !isPre)
        outOn_r[i] <= 1'b0;
      else if (xfDone)
      begin
        outLvl_r[i] <= target[i];
        outOn_r[i]  <= preOn_r[i];
      end
      else if (upRunning && !upBegin && target[i] > upFrom_r[i])
      begin
        outLvl_r[i] <= interp(upFrom_r[i], target[i], upProg);
        outOn_r[i]  <= 1'b1;
      end
      else if (downRunning && !downBegin && target[i] < downFrom_r[i])
        outLvl_r[i] <= interp(downFrom_r[i], target[i], downProg);
      else if (downDone && !preOn_r[i])
        outOn_r[i] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Preset store.
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (rst)
      begin
        preLvl_r[i] <= LEVEL_ZERO;
        preOn_r[i]  <= 1'b0;
      end
      else if (chanPre && panelSync_r.chan.idx == CH_IDX_W'(i))
      begin
        preLvl_r[i] <= panelSync_r.chan.level;
        preOn_r[i]  <= panelSync_r.chan.on;
      end
      else if (chanOut && fadeActive
               && panelSync_r.chan.idx == CH_IDX_W'(i))
        preOn_r[i] <= 1'b0;
      else if (preCut)
      begin
        preLvl_r[i] <= fileLvl_r[panelSync_r.fcmd.file][i];
        preOn_r[i]  <= fileOn_r[panelSync_r.fcmd.file][i];
      end
      else if ((prePlus || preZero) && fileOn_r[panelSync_r.fcmd.file][i])
      begin
        preLvl_r[i] <= preZero ? LEVEL_ZERO
                               : fileLvl_r[panelSync_r.fcmd.file][i];
        preOn_r[i]  <= 1'b1;
      end
      else if (op == OP_SET && isPre)
        preLvl_r[i] <= panelSync_r.setLevelPre;
      else if (op == OP_OFF && isPre)
        preOn_r[i] <= 1'b0;
      else if (primeReq && !preOn_r[i] && outOn_r[i])
      begin
        preLvl_r[i] <= LEVEL_ZERO;
        preOn_r[i]  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Files survive reset, since power-off loses everything but the files.
  always_ff @(posedge clk_sys)
  begin
    for (int f = 0; f < NUM_FILE; f++)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (clearAll)
        begin
          fileLvl_r[f][i] <= LEVEL_ZERO;
          fileOn_r[f][i]  <= 1'b0;
        end
        else if (fileWrite && panelSync_r.fcmd.file == FILE_IDX_W'(f))
        begin
          fileLvl_r[f][i] <= isPre ? preLvl_r[i] : outLvl_r[i];
          fileOn_r[f][i]  <= isPre ? preOn_r[i] : outOn_r[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mimic and flags; a set in the same cycle as a clear wins.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      mimic_r <= '0;
    else if (preLoad)
      mimic_r <= fileHot;
    else if (prePlus || preZero)
      mimic_r <= mimic_r | fileHot;
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      stat_r <= '0;
    else
    begin
      stat_r.modFlag   <= chanPre | (stat_r.modFlag & ~preLoad);
      stat_r.caution   <= chanPre | (stat_r.modFlag & ~preLoad);
      stat_r.zeroFlag  <= preZero | (stat_r.zeroFlag & ~preLoad);
      stat_r.xferFlag  <= (chanOut & fadeActive)
                        | (stat_r.xferFlag & ~preLoad);
      stat_r.primeFlag <= primeReq | (stat_r.primeFlag & ~preLoad);
      stat_r.primeComplete <= primeReq
                        | (stat_r.primeComplete
                           & ~|(outOn_r & ~preOn_r));
      stat_r.mixOn     <= stat_r.mixOn ^ press.mix;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  lsc_dimmer_mix #(.NUM_CH(NUM_CH)) dimmerMix (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .outLvl    (outLvl_r),
    .outOn     (outOn_r),
    .preLvl    (preLvl_r),
    .preOn     (preOn_r),
    .masterOut (panelSync_r.masterOut),
    .masterPre (panelSync_r.masterPre),
    .mixOn     (stat_r.mixOn),
    .enable    (panelSync_r.consolePower),
    .dimmer    (dimmer)
  );

  assign presetMimic = mimic_r;
  assign status      = stat_r;
  assign xfState     = xf_r;
endmodule

/* File: bench/lsc_crossfade_assertions.sv */
// Port checker for the crossfade block.
`timescale 1ns/100ps
module lsc_crossfade_assertions
  import lsc_pkg::*;
#(
  parameter int NUM_CH       = 16,
  parameter int NUM_FILE     = 100,
  parameter int SEC_CYCLES_P = SEC_CYCLES
)
(
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rst,
  // Panel
  input wire lsc_panel_type       panel,
  // Outputs
  input wire logic [LEVEL_W-1:0]  dimmer [NUM_CH],
  input wire logic [NUM_FILE-1:0] presetMimic,
  input wire lsc_status_type      status,
  input wire lsc_xf_type          xfState,
  input wire logic                upRunning,
  input wire logic                downRunning,
  input wire logic                upHalted,
  input wire logic                downHalted,
  input wire logic [TRAVEL_W-1:0] upTravel,
  input wire logic [TRAVEL_W-1:0] downTravel
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_auto_go;
    $rose(xfState == XF_ACTIVE);
  endsequence

  a_caution_mirror: assert property (status.caution == status.modFlag)
    else $error("caution differs from modification flag");
  a_travel_bound: assert property (upTravel <= 5'd20 && downTravel <= 5'd20)
    else $error("travel beyond full scale");
  a_up_halt: assert property (upHalted |-> upRunning)
    else $error("up fade halted while stopped");
  a_down_halt: assert property (downHalted |-> downRunning)
    else $error("down fade halted while stopped");
  a_dark_console: assert property ((!panel.consolePower)[*5] |-> dimmer[0] == LEVEL_ZERO)
    else $error("dimmer driven with console off");
  a_mimic_cause: assert property ($changed(presetMimic) |-> $past(panel.btn.fileGo))
    else $error("mimic changed without a file command");
  a_prime_cause: assert property ($rose(status.primeFlag) |->
    $past(panel.btn.prime) || $past(panel.btn.autoXf))
    else $error("priming flag without priming");
  a_mix_cause: assert property ($changed(status.mixOn) |-> $past(panel.btn.mix))
    else $error("merge toggled without a press");
  a_auto_runs: assert property (s_auto_go |=> upRunning && downRunning)
    else $error("auto crossfade without both fades");
  a_auto_primed: assert property (s_auto_go |-> status.primeComplete)
    else $error("auto crossfade without priming");
endmodule

bind lsc_crossfade lsc_crossfade_assertions #(
  .NUM_CH(NUM_CH), .NUM_FILE(NUM_FILE), .SEC_CYCLES_P(SEC_CYCLES_P)
) chk_u (
  .clk_sys(clk_sys), .rst(rst), .panel(panel), .dimmer(dimmer),
  .presetMimic(presetMimic), .status(status), .xfState(xfState),
  .upRunning(upRunning), .downRunning(downRunning), .upHalted(upHalted),
  .downHalted(downHalted), .upTravel(upTravel), .downTravel(downTravel)
);

/* File: bench/lsc_panel_model.sv */
// Operator panel model that holds each button press for several cycles.
`timescale 1ns/100ps
module lsc_panel_model
  import lsc_pkg::*;
(
  // Clock
  input  wire logic          clk_sys,
  // Requests
  input  wire lsc_btn_type   req,
  input  wire lsc_panel_type panelIn,
  // Panel pins
  output lsc_panel_type      panel
);
  lsc_btn_type held_r = '0;
  logic [2:0]  holdCnt_r = 3'h0;

  // A press is held long enough to pass the input synchronisers.
  always_ff @(posedge clk_sys)
  begin
    if (req != '0)
    begin
      held_r    <= req;
      holdCnt_r <= 3'h6;
    end
    else if (holdCnt_r != 3'h0)
      holdCnt_r <= holdCnt_r - 3'h1;
    else
      held_r <= '0;
  end

  always_comb
  begin
    panel     = panelIn;
    panel.btn = held_r;
  end
endmodule

/* File: bench/lsc_crossfade_tb_top.sv */
// Self-checking bench for the crossfade block.
`timescale 1ns/100ps
module lsc_crossfade_tb_top
  import lsc_pkg::*;
;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  lsc_panel_type      pIn;
  lsc_panel_type      panel;
  lsc_btn_type        req = '0;
  logic [LEVEL_W-1:0] dimmer [16];
  logic [99:0]        presetMimic;
  logic [99:0]        expMimic;
  lsc_status_type     status;
  lsc_xf_type         xfState;
  logic               upRunning, downRunning, upHalted, downHalted;
  logic [TRAVEL_W-1:0] upTravel, downTravel;
  int                 n_mismatch = 0;
  int                 num_checks = 0;
  int                 cyc = 0;
  int                 lvl, m;

  lsc_panel_model pm_u (.clk_sys(clk_sys), .req(req), .panelIn(pIn),
    .panel(panel));
  lsc_crossfade #(.SEC_CYCLES_P(400)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .panel(panel), .dimmer(dimmer), .presetMimic(presetMimic),
    .status(status), .xfState(xfState), .upRunning(upRunning),
    .downRunning(downRunning), .upHalted(upHalted), .downHalted(downHalted),
    .upTravel(upTravel), .downTravel(downTravel));

  initial
    forever #10 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input logic [127:0] s, input logic [127:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Buttons are indexed from the top bit of the button struct.
  task automatic press(input int i);
    req <= lsc_btn_type'(8'h80 >> i);
    @(posedge clk_sys);
    req <= '0;
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic fop(input lsc_op_type o, input logic p, input int f);
    pIn.fcmd <= '{o, p, FILE_IDX_W'(f)};
    press(6);
  endtask

  task automatic cw(input logic p, input int c, input int l);
    pIn.chan <= '{p, CH_IDX_W'(c), 1'b1, LEVEL_W'(l)};
    press(5);
  endtask

  function automatic int sc(input int l, input int f);
    return (l * (f + 1)) >> 8;
  endfunction

  ////////////////////////////////////////////////////////////
  initial
  begin
    pIn = '0;
    pIn.sysPower = 1'b1;
    pIn.consolePower = 1'b1;
    pIn.fileKey = 1'b1;
    pIn.masterOut = 8'hFF;
    pIn.masterPre = 8'hFF;
    pIn.durUp = 7'h01;
    pIn.durDown = 7'h01;
    void'($urandom(61715));
    lvl = $urandom_range(255, 80);
    m = $urandom_range(254, 0);
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk(status, '0);
    chk(xfState, XF_IDLE);
    chk(presetMimic, '0);
    cw(1'b1, 3, lvl);
    chk(status.modFlag, 1'b1);
    chk(status.caution, 1'b1);
    press(4);
    pIn.masterPre <= 8'(m);
    repeat (6) @(posedge clk_sys);
    chk(dimmer[3], sc(lvl, m));
    fop(OP_FILE, 1'b1, 5);
    expMimic = 100'h1 << 5;
    chk(presetMimic, expMimic);
    chk(status.modFlag, 1'b0);
    pIn.masterPre <= 8'hFF;
    fop(OP_OFF, 1'b1, 0);
    chk(dimmer[3], 0);
    chk(presetMimic, expMimic);
    fop(OP_CUT, 1'b1, 5);
    chk(dimmer[3], lvl);
    pIn.setLevelPre <= 8'h40;
    fop(OP_SET, 1'b1, 0);
    chk(dimmer[3], 8'h40);
    pIn.fileKey <= 1'b0;
    fop(OP_FILE, 1'b1, 5);
    pIn.fileKey <= 1'b1;
    fop(OP_CUT, 1'b1, 5);
    chk(dimmer[3], lvl);
    fop(OP_ZERO, 1'b1, 5);
    chk(status.zeroFlag, 1'b1);
    chk(dimmer[3], 0);
    cw(1'b0, 9, 8'h20);
    chk(status.primeComplete, 1'b0);
    press(3);
    chk({status.primeFlag, status.primeComplete}, 2'b11);
    cw(1'b0, 10, 8'h20);
    chk(status.primeComplete, 1'b0);
    fop(OP_CUT, 1'b1, 5);
    press(2);
    chk(xfState, XF_ACTIVE);
    chk({upRunning, downRunning}, 2'b11);
    cw(1'b0, 10, 8'h20);
    chk({status.xferFlag, status.primeComplete}, 2'b10);
    press(0);
    chk(xfState, XF_MODIFIED);
    chk({upRunning, downRunning}, 2'b01);
    press(2);
    chk(xfState, XF_IDLE);
    chk({upRunning, downRunning}, 2'b00);
    pIn.durUp <= 7'h00;
    press(0);
    chk({upRunning, upHalted, downHalted}, 3'b110);
    pIn.durUp <= 7'h01;
    press(0);
    chk(upRunning, 1'b0);
    press(4);
    press(2);
    for (int k = 0; k < 3000 && xfState !== XF_IDLE; k++)
      @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    chk(dimmer[3], lvl);
    chk(dimmer[9], 0);
    chk({upTravel, downTravel}, {5'd20, 5'd20});
    fop(OP_OFF, 1'b0, 0);
    press(4);
    chk(dimmer[3], lvl);
    pIn.clearKey <= 1'b1;
    press(7);
    pIn.clearKey <= 1'b0;
    fop(OP_CUT, 1'b1, 5);
    chk(dimmer[3], 0);
    close_out();
  end
endmodule
